/* File: pkg/twg_pkg.sv */
// Constants, register map and state codes for the waveform / one-shot timer.
// Assumes one system clock; the timer, count source and checker import this package whole.

package twg_pkg;

   // ******************************************************************
   // Register map (byte wide registers on the plain register port)
   // ******************************************************************
   localparam logic [2:0] TWG_ADDR_COUNT_CONTROL   = 3'h0;
   localparam logic [2:0] TWG_ADDR_ONESHOT_CONTROL = 3'h1;
   localparam logic [2:0] TWG_ADDR_PIN_IO_CONTROL  = 3'h2;
   localparam logic [2:0] TWG_ADDR_MODE            = 3'h3;
   localparam logic [2:0] TWG_ADDR_PRESCALER_VALUE = 3'h4;
   localparam logic [2:0] TWG_ADDR_SECONDARY_VALUE = 3'h5;
   localparam logic [2:0] TWG_ADDR_PRIMARY_VALUE   = 3'h6;

   // ******************************************************************
   // Field positions
   // ******************************************************************
   // count_control
   localparam int TWG_BIT_COUNT_START     = 0;
   localparam int TWG_BIT_COUNTING_STATUS = 1;
   localparam int TWG_BIT_FORCED_STOP     = 2;
   // oneshot_control
   localparam int TWG_BIT_ONESHOT_START   = 0;
   localparam int TWG_BIT_ONESHOT_STOP    = 1;
   localparam int TWG_BIT_ONESHOT_ACTIVE  = 2;
   // pin_io_control
   localparam int TWG_BIT_OUTPUT_LEVEL    = 0;
   localparam int TWG_BIT_EXT_EDGE_RISE   = 1;
   localparam int TWG_BIT_OUTPUT_SWITCH   = 2;
   localparam int TWG_BIT_EXT_TRIG_EN     = 3;
   // mode
   localparam int TWG_POS_MODE            = 0;
   localparam int TWG_BIT_WRITE_TARGET    = 3;
   localparam int TWG_POS_SRC_SEL         = 4;

   // ******************************************************************
   // Reset values and encodings
   // ******************************************************************
   localparam logic [7:0] TWG_VALUE_RESET   = 8'hFF;
   localparam logic [7:0] TWG_CTRL_RESET    = 8'h00;
   localparam logic [1:0] TWG_MODE_TIMER    = 2'h0;
   localparam logic [1:0] TWG_MODE_WAVEFORM = 2'h1;
   localparam logic [1:0] TWG_MODE_ONESHOT  = 2'h2;
   localparam logic [1:0] TWG_SRC_TAP_A     = 2'h0;
   localparam logic [1:0] TWG_SRC_TAP_B     = 2'h1;
   localparam logic [1:0] TWG_SRC_TAP_C     = 2'h2;
   localparam logic [1:0] TWG_SRC_COMPANION = 2'h3;
   // Divider for the count-source taps: tap b every 2, tap c every 8 cycles
   localparam logic [2:0] TWG_TAP_C_LAST    = 3'h7;

   // Counting phase, one-hot
   typedef enum logic [2:0] {
      TWG_ST_IDLE = 3'b001,
      TWG_ST_PRI  = 3'b010,
      TWG_ST_SEC  = 3'b100
   } twg_state_t;

endpackage : twg_pkg

/* File: rtl/twg_count_src.sv */
// Count-source selector: the system clock, two divided taps of it, or the
// companion timer underflow pulse, delivered as a one-cycle tick.
// Assumes the companion underflow is a one-cycle pulse on i_clk_sys.

`timescale 1ns/10ps

module twg_count_src
   import twg_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_b,
   input  wire logic [1:0] i_src_sel,
   input  wire logic       i_companion_uf,
   output logic            o_tick
);

   logic [2:0] div_q;
   logic [2:0] div_d;

   // ******************************************************************
   // Free-running divider feeding the taps
   // ******************************************************************
   always_comb begin
      div_d = div_q + 3'h1;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_d;
      end
   end

   // Tap select; companion pulse is same-domain so it is used directly
   always_comb begin
      unique case (i_src_sel)
         TWG_SRC_TAP_A: o_tick = 1'b1;
         TWG_SRC_TAP_B: o_tick = div_q[0];
         TWG_SRC_TAP_C: o_tick = (div_q == TWG_TAP_C_LAST);
         default:       o_tick = i_companion_uf;
      endcase
   end

endmodule : twg_count_src

/* File: rtl/twg_timer.sv */
// Waveform / one-shot timer: 8-bit prescaler, 8-bit down counter with
// primary and secondary reload values, pulse output pin and interrupt.
// Assumes a plain byte register port on i_clk_sys and an async trigger pin.
//
// Functional notes
// - Waveform mode toggles output on each underflow
// - Waveform runs always start with primary value
// - Decrement; reload primary and secondary alternately
// - Count source: three taps or companion underflow
// - Intervals last (n+1)(m+1) and (n+1)(p+1)
// - Writing count start one starts waveform
// - Start cleared or forced stop halts counting
// - Interrupt after underflow ending secondary interval
// - Output switch picks waveform or port latch
// - Output switch takes effect at start/interrupt
// - Level select sets polarity and pulse level
// - Stopped writes load counter; running, reload only, except timer mode with write target clear
// - Primary and prescaler reads return live count
// - One-shot runs once for primary period
// - One-shot trigger by software or pin edge
// - One-shot underflow reloads, ends, clears flag
// - One-shot stop, start clear, forced stop end run
// - One-shot width is (n+1)(m+1) source cycles
// - One-shot interrupt when pulse ends
// - Trigger enable makes pin a trigger source
// - One-shot running writes reach reload only
// - Triggers ignored while one-shot is active
// - Forced stop returns values to all ones

`timescale 1ns/10ps

module twg_timer
   import twg_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_b,
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic       i_companion_uf,
   input  wire logic       i_ext_interrupt_pin,
   input  wire logic       i_port_latch_bit,
   output logic            o_ext_interrupt_level,
   output logic            o_pulse_out_pin,
   output logic            o_irq
);

   // ******************************************************************
   // Declarations
   // ******************************************************************
   logic       start_q,    start_d;
   logic       cstf_q,     cstf_d;
   logic       lvl_q,      lvl_d;
   logic       edge_q,     edge_d;
   logic       sw_q,       sw_d;
   logic       sw_eff_q,   sw_eff_d;
   logic       trg_en_q,   trg_en_d;
   logic       wtc_q,      wtc_d;
   logic [1:0] mode_q,     mode_d;
   logic [1:0] src_q,      src_d;
   logic [7:0] pre_rl_q,   pre_rl_d;
   logic [7:0] pri_rl_q,   pri_rl_d;
   logic [7:0] sec_rl_q,   sec_rl_d;
   logic [7:0] pre_cnt_q,  pre_cnt_d;
   logic [7:0] main_cnt_q, main_cnt_d;
   twg_state_t state_q,    state_d;
   logic       wave_q,     wave_d;
   logic       pin_q,      pin_d;
   logic       irq_q,      irq_d;
   logic [7:0] rdata_q,    rdata_d;

   logic       tick;
   logic       ext_edge;
   logic       wr_cc;
   logic       wr_oc;
   logic       forced_stop;
   logic       stopped;
   logic       is_wave;
   logic       is_oneshot;
   logic       trigger;
   logic       os_stop;
   logic       run;
   logic       pre_uf;
   logic       main_uf;
   logic       start_rise;

   // ******************************************************************
   // Count source and trigger pin
   // ******************************************************************
   twg_count_src u_src (
      .i_clk_sys      (i_clk_sys),
      .i_rst_b        (i_rst_b),
      .i_src_sel      (src_q),
      .i_companion_uf (i_companion_uf),
      .o_tick         (tick)
   );

   twg_trig_edge u_edge (
      .i_clk_sys  (i_clk_sys),
      .i_rst_b    (i_rst_b),
      .i_pin      (i_ext_interrupt_pin),
      .i_rise_sel (edge_q),
      .o_level    (o_ext_interrupt_level),
      .o_edge     (ext_edge)
   );

   // ******************************************************************
   // Decode of strobes and run conditions
   // ******************************************************************
   always_comb begin
      wr_cc       = i_wr && (i_addr == TWG_ADDR_COUNT_CONTROL);
      wr_oc       = i_wr && (i_addr == TWG_ADDR_ONESHOT_CONTROL);
      forced_stop = wr_cc && i_wdata[TWG_BIT_FORCED_STOP];
      stopped     = !start_q && !cstf_q;
      is_wave     = (mode_q == TWG_MODE_WAVEFORM);
      is_oneshot  = (mode_q == TWG_MODE_ONESHOT);
      start_rise  = start_q && !cstf_q;
      // Software or pin trigger, refused while a shot runs
      trigger     = is_oneshot && cstf_q && start_q && (state_q == TWG_ST_IDLE)
                    && ((wr_oc && i_wdata[TWG_BIT_ONESHOT_START]) || (trg_en_q && ext_edge));
      // One-shot stop bit or count start cleared; forced stop is handled below
      os_stop     = is_oneshot && (state_q != TWG_ST_IDLE)
                    && ((wr_oc && i_wdata[TWG_BIT_ONESHOT_STOP]) || !start_q);
      run         = cstf_q && start_q && (state_q != TWG_ST_IDLE) && tick;
      // Prescaler underflow clocks the main counter
      pre_uf      = run && (pre_cnt_q == 8'h00);
      main_uf     = pre_uf && (main_cnt_q == 8'h00);
   end

   // ******************************************************************
   // Control registers and next-state logic
   // ******************************************************************
   always_comb begin
      start_d    = start_q;
      cstf_d     = start_q;
      lvl_d      = lvl_q;
      edge_d     = edge_q;
      sw_d       = sw_q;
      sw_eff_d   = sw_eff_q;
      trg_en_d   = trg_en_q;
      wtc_d      = wtc_q;
      mode_d     = mode_q;
      src_d      = src_q;
      pre_rl_d   = pre_rl_q;
      pri_rl_d   = pri_rl_q;
      sec_rl_d   = sec_rl_q;
      pre_cnt_d  = pre_cnt_q;
      main_cnt_d = main_cnt_q;
      state_d    = state_q;
      wave_d     = wave_q;
      irq_d      = 1'b0;

      // Register writes; mode and source only change while stopped
      if (wr_cc) begin
         start_d = i_wdata[TWG_BIT_COUNT_START];
      end
      if (i_wr && (i_addr == TWG_ADDR_PIN_IO_CONTROL)) begin
         lvl_d    = i_wdata[TWG_BIT_OUTPUT_LEVEL];
         edge_d   = i_wdata[TWG_BIT_EXT_EDGE_RISE];
         sw_d     = i_wdata[TWG_BIT_OUTPUT_SWITCH];
         trg_en_d = i_wdata[TWG_BIT_EXT_TRIG_EN];
      end
      if (i_wr && (i_addr == TWG_ADDR_MODE) && stopped) begin
         mode_d = i_wdata[TWG_POS_MODE +: 2];
         wtc_d  = i_wdata[TWG_BIT_WRITE_TARGET];
         src_d  = i_wdata[TWG_POS_SRC_SEL +: 2];
      end

      // Counting: prescaler first, main counter on its underflow
      if (run) begin
         if (pre_uf) begin
            pre_cnt_d = pre_rl_q;
            if (main_uf) begin
               if (is_wave) begin
                  // Alternate reloads and flip the waveform
                  wave_d = ~wave_q;
                  if (state_q == TWG_ST_PRI) begin
                     main_cnt_d = sec_rl_q;
                     state_d    = TWG_ST_SEC;
                  end else begin
                     main_cnt_d = pri_rl_q;
                     state_d    = TWG_ST_PRI;
                     irq_d      = 1'b1;
                     sw_eff_d   = sw_q;
                  end
               end else begin
                  // One shot ends: reload, drop flag, interrupt
                  main_cnt_d = pri_rl_q;
                  state_d    = TWG_ST_IDLE;
                  irq_d      = 1'b1;
               end
            end else begin
               main_cnt_d = main_cnt_q - 8'h01;
            end
         end else begin
            pre_cnt_d = pre_cnt_q - 8'h01;
         end
      end

      // Waveform run begins on the primary value
      if (is_wave && start_rise) begin
         state_d    = TWG_ST_PRI;
         wave_d     = 1'b0;
         pre_cnt_d  = pre_rl_q;
         main_cnt_d = pri_rl_q;
         sw_eff_d   = sw_q;
      end
      // Waveform stop when count start is cleared
      if (is_wave && !start_q) begin
         state_d = TWG_ST_IDLE;
      end

      // Accepted one-shot trigger starts a primary-length run
      if (trigger) begin
         state_d    = TWG_ST_PRI;
         pre_cnt_d  = pre_rl_q;
         main_cnt_d = pri_rl_q;
      end
      // Stopping a shot reloads the counters
      if (os_stop) begin
         state_d    = TWG_ST_IDLE;
         pre_cnt_d  = pre_rl_q;
         main_cnt_d = pri_rl_q;
      end

      // Prescaler and primary writes: stopped, or timer mode with write target clear, loads both; otherwise, and secondary always, reload only
      if (i_wr && (i_addr == TWG_ADDR_PRESCALER_VALUE)) begin
         pre_rl_d = i_wdata;
         if (stopped || (!wtc_q && mode_q == TWG_MODE_TIMER)) begin
            pre_cnt_d = i_wdata;
         end
      end
      if (i_wr && (i_addr == TWG_ADDR_PRIMARY_VALUE)) begin
         pri_rl_d = i_wdata;
         if (stopped || (!wtc_q && mode_q == TWG_MODE_TIMER)) begin
            main_cnt_d = i_wdata;
         end
      end
      if (i_wr && (i_addr == TWG_ADDR_SECONDARY_VALUE)) begin
         sec_rl_d = i_wdata;
      end

      // Forced stop wins over all counter, state and value updates and restores all ones; a same-cycle interrupt still fires
      if (forced_stop) begin
         start_d    = 1'b0;
         cstf_d     = 1'b0;
         state_d    = TWG_ST_IDLE;
         pre_rl_d   = TWG_VALUE_RESET;
         pri_rl_d   = TWG_VALUE_RESET;
         sec_rl_d   = TWG_VALUE_RESET;
         pre_cnt_d  = TWG_VALUE_RESET;
         main_cnt_d = TWG_VALUE_RESET;
         wave_d     = 1'b0;
      end
   end

   // ******************************************************************
   // Output pin and read data
   // ******************************************************************
   always_comb begin
      // Level select sets polarity of both modes
      if (is_wave) begin
         // Switch picks waveform or port latch
         // Next values, so the pin moves on the same edge as the interrupt
         pin_d = sw_eff_d ? i_port_latch_bit
                          : ((state_d == TWG_ST_IDLE) ? lvl_q : (wave_d ^ ~lvl_q));
      end else if (is_oneshot) begin
         pin_d = (state_d != TWG_ST_IDLE) ? ~lvl_q : lvl_q;
      end else begin
         pin_d = i_port_latch_bit;
      end

      // Read mux; live counts for primary and prescaler
      rdata_d = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            TWG_ADDR_COUNT_CONTROL: begin
               rdata_d[TWG_BIT_COUNT_START]     = start_q;
               rdata_d[TWG_BIT_COUNTING_STATUS] = cstf_q;
            end
            TWG_ADDR_ONESHOT_CONTROL: begin
               rdata_d[TWG_BIT_ONESHOT_ACTIVE] = is_oneshot && (state_q != TWG_ST_IDLE);
            end
            TWG_ADDR_PIN_IO_CONTROL: begin
               rdata_d[TWG_BIT_OUTPUT_LEVEL]  = lvl_q;
               rdata_d[TWG_BIT_EXT_EDGE_RISE] = edge_q;
               rdata_d[TWG_BIT_OUTPUT_SWITCH] = sw_q;
               rdata_d[TWG_BIT_EXT_TRIG_EN]   = trg_en_q;
            end
            TWG_ADDR_MODE: begin
               rdata_d[TWG_POS_MODE +: 2]     = mode_q;
               rdata_d[TWG_BIT_WRITE_TARGET]  = wtc_q;
               rdata_d[TWG_POS_SRC_SEL +: 2]  = src_q;
            end
            TWG_ADDR_PRESCALER_VALUE: rdata_d = pre_cnt_q;
            TWG_ADDR_SECONDARY_VALUE: rdata_d = sec_rl_q;
            TWG_ADDR_PRIMARY_VALUE:   rdata_d = main_cnt_q;
            default:                  rdata_d = 8'h00;
         endcase
      end
   end

   // ******************************************************************
   // State registers
   // ******************************************************************
   // One register stage delays pin and interrupt past the underflow tick,
   // standing in for the half count-source cycle of the original timing.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         start_q    <= 1'b0;
         cstf_q     <= 1'b0;
         lvl_q      <= 1'b0;
         edge_q     <= 1'b0;
         sw_q       <= 1'b0;
         sw_eff_q   <= 1'b0;
         trg_en_q   <= 1'b0;
         wtc_q      <= 1'b0;
         mode_q     <= TWG_MODE_TIMER;
         src_q      <= TWG_SRC_TAP_A;
         pre_rl_q   <= TWG_VALUE_RESET;
         pri_rl_q   <= TWG_VALUE_RESET;
         sec_rl_q   <= TWG_VALUE_RESET;
         pre_cnt_q  <= TWG_VALUE_RESET;
         main_cnt_q <= TWG_VALUE_RESET;
         state_q    <= TWG_ST_IDLE;
         wave_q     <= 1'b0;
         pin_q      <= 1'b0;
         irq_q      <= 1'b0;
         rdata_q    <= TWG_CTRL_RESET;
      end else begin
         start_q    <= start_d;
         cstf_q     <= cstf_d;
         lvl_q      <= lvl_d;
         edge_q     <= edge_d;
         sw_q       <= sw_d;
         sw_eff_q   <= sw_eff_d;
         trg_en_q   <= trg_en_d;
         wtc_q      <= wtc_d;
         mode_q     <= mode_d;
         src_q      <= src_d;
         pre_rl_q   <= pre_rl_d;
         pri_rl_q   <= pri_rl_d;
         sec_rl_q   <= sec_rl_d;
         pre_cnt_q  <= pre_cnt_d;
         main_cnt_q <= main_cnt_d;
         state_q    <= state_d;
         wave_q     <= wave_d;
         pin_q      <= pin_d;
         irq_q      <= irq_d;
         rdata_q    <= rdata_d;
      end
   end

   always_comb begin
      o_pulse_out_pin = pin_q;
      o_irq           = irq_q;
      o_rdata         = rdata_q;
   end

endmodule : twg_timer

/* File: rtl/twg_trig_edge.sv */
// External interrupt pin synchroniser with edge detection.
// Assumes the pin is asynchronous to i_clk_sys.

`timescale 1ns/10ps

module twg_trig_edge (
   input  wire logic i_clk_sys,
   input  wire logic i_rst_b,
   input  wire logic i_pin,
   input  wire logic i_rise_sel,
   output logic      o_level,
   output logic      o_edge
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   // ******************************************************************
   // Two-flop synchroniser, then a third flop for edge history
   // ******************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         last_q <= 1'b1;
      end else begin
         meta_q <= i_pin;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Only the second and third flops feed the edge logic
   always_comb begin
      o_level = sync_q;
      o_edge  = i_rise_sel ? (sync_q & ~last_q) : (~sync_q & last_q);
   end

endmodule : twg_trig_edge

/* File: test/tb.sv */
// Self-checking bench for the waveform / one-shot timer.
// Assumes twg_timer, the far-side model and the bound checker; 25 MHz clock.
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %0t: got %0h exp %0h", $time, (g), (e)); end end
module tb;
   logic        clk_sys = 1'b0, rst_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0, cuf = 1'b0;
   logic        latch = 1'b0, fire = 1'b0, lvl = 1'b0, ext_pin, ext_lvl, pout, irq;
   logic [2:0]  addr = 3'h0;
   logic [7:0]  wdata = 8'h00, rdata, v;
   logic [15:0] width;
   int          comparisons = 0, miscompares = 0, cyc = 0, ccnt = 0, n;
   // Mode, source, prescaler, primary, secondary, level, first and second interval
   int rows [6][8] = '{'{1, 0, 0, 1, 0, 0, 2, 1}, '{1, 1, 1, 2, 3, 1, 12, 16}, '{1, 2, 0, 0, 1, 0, 8, 16},
      '{1, 3, 2, 1, 0, 1, 18, 9}, '{2, 0, 0, 1, 0, 0, 2, 0}, '{2, 0, 3, 4, 0, 1, 20, 0}};
   twg_timer uut (.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
      .i_rd(rd_s), .o_rdata(rdata), .i_companion_uf(cuf), .i_ext_interrupt_pin(ext_pin),
      .i_port_latch_bit(latch), .o_ext_interrupt_level(ext_lvl), .o_pulse_out_pin(pout), .o_irq(irq));
   twg_far far (.i_clk_sys(clk_sys), .i_fire(fire), .i_pulse(pout), .i_idle(lvl), .o_ext_pin(ext_pin),
      .o_width(width));
   // Clock
   always #20 clk_sys = ~clk_sys;
   // Companion underflow every third cycle, and the run ceiling
   always @(posedge clk_sys) begin
      ccnt <= (ccnt == 2) ? 0 : ccnt + 1;
      cuf  <= (ccnt == 2);
      cyc  <= cyc + 1;
      if (cyc == 40000) begin miscompares++; end_of_test; end
   end
   // ******
   // Bus and timing helpers
   // ******
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys); addr <= a; wdata <= d; wr_s <= 1'b1;
      @(posedge clk_sys); wr_s <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys); addr <= a; rd_s <= 1'b1;
      @(posedge clk_sys); rd_s <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic kick;
      @(posedge clk_sys); fire <= 1'b1;
      @(posedge clk_sys); fire <= 1'b0;
   endtask : kick
   // Cycles until the pin changes, capped at lim
   task automatic meas(output int k, input int lim);
      logic s;
      #1 s = pout;
      k = 0;
      while (pout === s && k < lim) begin @(posedge clk_sys); #1; k++; end
   endtask : meas
   task automatic wait_irq;
      int k = 0;
      do begin @(posedge clk_sys); #1; k++; end while (irq !== 1'b1 && k < 3000);
      if (k >= 3000) `CHK(k, 0)
   endtask : wait_irq
   // Forced stop, program everything, start; mode 1 shows primary level, 2 idle
   task automatic setup(input int md, input int src, input int pn, input int pm, input int pp, input int l);
      wr(0, 8'h04);
      wr(3, 8'(md + 8 + src * 16));
      wr(2, 8'(l + 2));
      lvl <= l[0];
      wr(4, 8'(pn));
      wr(5, 8'(pp));
      wr(6, 8'(pm));
      wr(0, 8'h01);
      repeat (2) @(posedge clk_sys);
      #1 `CHK(pout, 1'(l ^ (md == 1)))
   endtask : setup
   task automatic end_of_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   // ******
   // Main sequence
   // ******
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int r = 0; r < 6; r++) begin
         setup(rows[r][0], rows[r][1], rows[r][2], rows[r][3], rows[r][4], rows[r][5]);
         if (rows[r][0] == 2) begin
            wr(1, 8'h01);
            meas(n, 3000);
            `CHK(n, rows[r][6])
            `CHK(irq, 1'b1)
         end else begin
            wait_irq;
            `CHK(pout, ~lvl)
            meas(n, 3000);
            `CHK(n, rows[r][6])
            meas(n, 3000);
            `CHK(n, rows[r][7])
         end
      end
      // Live read in secondary, running write reaches the next primary only
      setup(1, 0, 0, 20, 30, 0);
      wait_irq;
      repeat (25) @(posedge clk_sys);
      rd(6, v);
      `CHK(v > 20 && v <= 30, 1'b1)
      wr(6, 8'h03);
      wait_irq;
      meas(n, 3000);
      `CHK(n, 4)
      wr(0, 8'h00);
      meas(n, 80);
      `CHK(n, 80)
      // Forced stop while running
      wr(0, 8'h01);
      repeat (10) @(posedge clk_sys);
      wr(0, 8'h04);
      for (int a = 4; a < 7; a++) begin rd(3'(a), v); `CHK(v, 8'hFF) end
      rd(0, v);
      `CHK(v[2:0], 3'h0)
      // Pin trigger: ignored until enabled, then no retrigger mid-pulse
      setup(2, 0, 0, 9, 0, 0);
      kick;
      meas(n, 30);
      `CHK(n, 30)
      wr(2, 8'h0A);
      kick;
      meas(n, 20);
      rd(1, v);
      `CHK(v[2], 1'b1)
      wr(1, 8'h01);
      meas(n, 3000);
      @(posedge clk_sys);
      #1 `CHK(width, 16'h000A)
      rd(1, v);
      `CHK(v[2], 1'b0)
      // One-shot stopped part way
      wr(1, 8'h01);
      repeat (3) @(posedge clk_sys);
      wr(1, 8'h02);
      repeat (2) @(posedge clk_sys);
      #1 `CHK(pout, 1'b0)
      rd(6, v);
      `CHK(v, 8'h09)
      // Output switch waits for the interrupt, then the pin follows the port latch
      setup(1, 0, 0, 9, 9, 0);
      wait_irq;
      wr(2, 8'h06);
      meas(n, 30);
      `CHK(n <= 11, 1'b1)
      wait_irq;
      `CHK(pout, 1'b0)
      @(posedge clk_sys) latch <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 `CHK(pout, 1'b1)
      // Second reset in mid-run
      @(posedge clk_sys) rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(0, v);
      `CHK(v, 8'h00)
      rd(6, v);
      `CHK(v, 8'hFF)
      rd(7, v);
      `CHK(v, 8'h00)
      `CHK(ext_lvl, 1'b1)
      end_of_test;
   end
endmodule : tb

/* File: test/twg_chk.sv */
// Port checker for the waveform / one-shot timer.
// Assumes it is bound to twg_timer and sees only its ports.
`timescale 1ns/10ps
module twg_chk
   import twg_pkg::*;
(
   input wire logic       i_clk_sys,
   input wire logic       i_rst_b,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       i_ext_interrupt_pin,
   input wire logic       o_ext_interrupt_level,
   input wire logic       o_pulse_out_pin,
   input wire logic       o_irq
);
   // ******
   // Software view of mode, level, switch and forced stop
   // ******
   logic [1:0] mode_q, mode_d;
   logic       lvl_q, lvl_d, sw_q, sw_d, fs_q, fs_d;
   // Mirror only; mode is never rewritten while running, so no refusal is modelled
   always_comb begin
      mode_d = mode_q;
      lvl_d  = lvl_q;
      sw_d   = sw_q;
      fs_d   = fs_q;
      if (i_wr && i_addr == TWG_ADDR_MODE) mode_d = i_wdata[1:0];
      if (i_wr && i_addr == TWG_ADDR_PIN_IO_CONTROL) lvl_d = i_wdata[TWG_BIT_OUTPUT_LEVEL];
      if (i_wr && i_addr == TWG_ADDR_PIN_IO_CONTROL) sw_d = i_wdata[TWG_BIT_OUTPUT_SWITCH];
      if (i_wr && i_addr >= TWG_ADDR_PRESCALER_VALUE) fs_d = 1'b0;
      if (i_wr && i_addr == TWG_ADDR_COUNT_CONTROL) fs_d = i_wdata[2] | (fs_q & ~i_wdata[0]);
   end
   // Registered mirror
   always_ff @(posedge i_clk_sys) begin
      {mode_q, lvl_q, sw_q, fs_q} <= i_rst_b ? {mode_d, lvl_d, sw_d, fs_d} : 5'h00;
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   // ******
   // Assertions
   // ******
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
   unmapped_read_a: assert property ($past(i_rd) && $past(i_addr) == 3'h7 |-> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   stop_reads_zero_a: assert property ($past(i_rd) && $past(i_addr) == 3'h0 |-> !o_rdata[2])
      else $error("forced stop bit read back");
   forced_ones_a: assert property ($past(i_rd) && $past(fs_q) && $past(i_addr) inside {[3'h4:3'h6]}
      |-> o_rdata == TWG_VALUE_RESET) else $error("value not all ones after forced stop");
   irq_single_a: assert property (o_irq |=> !o_irq) else $error("interrupt longer than one cycle");
   wave_irq_level_a: assert property (o_irq && mode_q == TWG_MODE_WAVEFORM && !sw_q && !$past(sw_q)
      |-> o_pulse_out_pin == !lvl_q && $changed(o_pulse_out_pin)) else $error("waveform interrupt off edge");
   shot_irq_idle_a: assert property (o_irq && mode_q == TWG_MODE_ONESHOT
      |-> o_pulse_out_pin == lvl_q && $past(o_pulse_out_pin) != lvl_q) else $error("one-shot interrupt off end");
   ext_sync_a: assert property ($past(i_rst_b) && $past(i_rst_b, 2)
      |-> o_ext_interrupt_level == $past(i_ext_interrupt_pin, 2)) else $error("pin level sync wrong");
   wave_irq_c: cover property (o_irq && mode_q == TWG_MODE_WAVEFORM);
   shot_irq_c: cover property (o_irq && mode_q == TWG_MODE_ONESHOT);
   forced_read_c: cover property (i_rd && fs_q);
endmodule : twg_chk
bind twg_timer twg_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_interrupt_pin(i_ext_interrupt_pin),
   .o_ext_interrupt_level(o_ext_interrupt_level), .o_pulse_out_pin(o_pulse_out_pin), .o_irq(o_irq));

/* File: test/twg_far.sv */
// Far-side model: trigger source on the external pin and load on the pulse pin.
// Assumes the bench asks for a trigger with a one-cycle fire strobe.
`timescale 1ns/10ps
module twg_far (
   input  wire logic        i_clk_sys,
   input  wire logic        i_fire,
   input  wire logic        i_pulse,
   input  wire logic        i_idle,
   output logic             o_ext_pin,
   output logic      [15:0] o_width
);
   logic [2:0]  low_q = 3'h0;
   logic [15:0] run_q = 16'h0000;
   initial o_width = 16'h0000;
   // Pin rests high as with a pull-up; a dip of four cycles ends in a rising edge
   assign o_ext_pin = (low_q == 3'h0);
   // Dip timer and width of the last active pulse, so the bench need not count
   always @(posedge i_clk_sys) begin
      low_q <= i_fire ? 3'h4 : (low_q != 3'h0) ? low_q - 3'h1 : low_q;
      run_q <= (i_pulse != i_idle) ? run_q + 16'h0001 : 16'h0000;
      if (i_pulse == i_idle && run_q != 16'h0000) o_width <= run_q;
   end
endmodule : twg_far
